//--- shared/rgbc_pkg.sv
// Register map, field layout and reset values of the LED configuration bank
`default_nettype none

package rgbc_pkg;

  typedef logic [7:0] rgbc_byte_t;

  // Register offsets
  localparam rgbc_byte_t OFF_GLOBAL_OPTIONS      = 8'h01;
  localparam rgbc_byte_t OFF_MODULE_GROUP_SELECT = 8'h02;
  localparam rgbc_byte_t OFF_GROUP_INTENSITY     = 8'h03;
  localparam rgbc_byte_t OFF_GROUP_FIRST_COLOR   = 8'h04;
  localparam rgbc_byte_t OFF_GROUP_SECOND_COLOR  = 8'h05;
  localparam rgbc_byte_t OFF_GROUP_THIRD_COLOR   = 8'h06;
  localparam rgbc_byte_t OFF_MODULE0_INTENSITY   = 8'h07;

  // Global options field positions
  localparam int BIT_LOG_SCALE    = 5;
  localparam int BIT_POWER_SAVE   = 4;
  localparam int BIT_AUTO_INCR    = 3;
  localparam int BIT_DITHER       = 2;
  localparam int BIT_HIGH_CURRENT = 1;
  localparam int BIT_SHUTDOWN     = 0;

  // Writable bits of global options; bits 7 to 6 are reserved
  localparam rgbc_byte_t OPT_WRITE_MASK = 8'h3F;

  // Values after reset
  localparam rgbc_byte_t RST_GLOBAL_OPTIONS      = 8'h3C;
  localparam rgbc_byte_t RST_MODULE_GROUP_SELECT = 8'h00;
  localparam rgbc_byte_t RST_GROUP_INTENSITY     = 8'hFF;
  localparam rgbc_byte_t RST_GROUP_COLOR         = 8'h00;
  localparam rgbc_byte_t RST_MODULE_INTENSITY    = 8'hFF;
  localparam rgbc_byte_t RST_MODULE_COLOR        = 8'h00;
  localparam rgbc_byte_t RST_READ_DATA           = 8'h00;

  // Colors per RGB module
  localparam int COLORS_PER_MODULE = 3;

endpackage

`default_nettype wire

//--- rtl/rgbc_mod_sel.sv
// Per-module source selection between group and independent control
`timescale 1ns/100ps
`default_nettype none

module rgbc_mod_sel
(
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic                         group_en,
  input  wire logic                         shutdown,
  input  wire logic [2:0][7:0]              grp_color,
  input  wire logic [7:0]                   grp_int,
  input  wire logic [2:0][7:0]              own_color,
  input  wire logic [7:0]                   own_int,
  output logic      [2:0][7:0]              color_q,
  output logic      [7:0]                   int_q
);

  logic [2:0][7:0] color_d;
  logic [7:0]      int_d;

  // Grouped module takes group values and ignores its own
  assign int_d   = group_en ? grp_int : own_int;
  // Shutdown blanks every color regardless of source
  assign color_d = shutdown ? '0 :
                   (group_en ? grp_color : own_color);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      color_q <= {rgbc_pkg::COLORS_PER_MODULE{rgbc_pkg::RST_MODULE_COLOR}};
      int_q   <= rgbc_pkg::RST_MODULE_INTENSITY;
    end
    else
    begin
      color_q <= color_d;
      int_q   <= int_d;
    end
  end

endmodule

`default_nettype wire

//--- rtl/rgbc_cfg_bank.sv
// Configuration and group-control register bank of the RGB LED driver
//
// Contract
// - Options bit 5 set picks log dimming, clear picks linear, reset set.
// - Options bit 4 enables automatic power saving when set, reset set.
// - Options bit 3 enables register-address auto-increment, reset set.
// - Options bit 2 enables PWM dithering when set, reset set.
// - Options bit 1 set gives the 35 mA ceiling, clear gives 25.5 mA.
// - Options bit 0 forces all LED outputs off when set, reset clear.
// - Group-select bit n puts module n in group control, all reset clear.
// - Group intensity scales grouped brightness linearly, reset FFh.
// - Three group color registers hold mixing percentages, each reset zero.
// - Each module intensity register scales that module, each reset FFh; a grouped module takes group intensity and ignores its own.
`timescale 1ns/100ps
`default_nettype none

module rgbc_cfg_bank
#(
  parameter int NUM_MOD = 8
)
(
  input  wire logic                         CLK,
  input  wire logic                         NRST,
  input  wire logic [7:0]                   REG_ADDR,
  input  wire logic                         REG_WR,
  input  wire logic [7:0]                   REG_WDATA,
  output logic      [7:0]                   REG_RDATA,
  input  wire logic [NUM_MOD*3-1:0][7:0]    OWN_COLOR,
  output logic      [NUM_MOD*3-1:0][7:0]    MOD_COLOR,
  output logic      [NUM_MOD-1:0][7:0]      MOD_INTENSITY,
  output logic      [NUM_MOD-1:0]           GROUP_SELECT,
  output logic                              LOG_SCALE,
  output logic                              POWER_SAVE,
  output logic                              AUTO_INCR,
  output logic                              DITHER,
  output logic                              HIGH_CURRENT,
  output logic                              SHUTDOWN
);

  localparam logic [7:0] NUM_MOD_B = 8'(NUM_MOD);

  logic [7:0]              opt_q;
  logic [7:0]              grp_sel_q;
  logic [7:0]              grp_int_q;
  logic [7:0]              grp_first_q;
  logic [7:0]              grp_second_q;
  logic [7:0]              grp_third_q;
  logic [NUM_MOD-1:0][7:0] mod_int_q;
  logic [7:0]              rdata_q;
  logic [7:0]              rdata_d;
  logic [2:0][7:0]         grp_color;

  // Module intensity window decode, shared by write and read paths
  function automatic logic mod_hit(input logic [7:0] a);
    mod_hit = (a >= rgbc_pkg::OFF_MODULE0_INTENSITY) &&
              (a <  rgbc_pkg::OFF_MODULE0_INTENSITY + NUM_MOD_B);
  endfunction

  function automatic logic [7:0] mod_idx(input logic [7:0] a);
    mod_idx = a - rgbc_pkg::OFF_MODULE0_INTENSITY;
  endfunction

  wire        wr_opt    = REG_WR &&
                          (REG_ADDR == rgbc_pkg::OFF_GLOBAL_OPTIONS);
  wire        wr_sel    = REG_WR &&
                          (REG_ADDR == rgbc_pkg::OFF_MODULE_GROUP_SELECT);
  wire        wr_gint   = REG_WR &&
                          (REG_ADDR == rgbc_pkg::OFF_GROUP_INTENSITY);
  wire        wr_first  = REG_WR &&
                          (REG_ADDR == rgbc_pkg::OFF_GROUP_FIRST_COLOR);
  wire        wr_second = REG_WR &&
                          (REG_ADDR == rgbc_pkg::OFF_GROUP_SECOND_COLOR);
  wire        wr_third  = REG_WR &&
                          (REG_ADDR == rgbc_pkg::OFF_GROUP_THIRD_COLOR);
  wire        wr_mod    = REG_WR && mod_hit(REG_ADDR);
  wire [7:0]  wr_idx    = mod_idx(REG_ADDR);

  // Reserved option bits are dropped on write
  wire [7:0]  opt_d     = REG_WDATA & rgbc_pkg::OPT_WRITE_MASK;

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (REG_ADDR == rgbc_pkg::OFF_GLOBAL_OPTIONS)
      rdata_d = opt_q;
    else if (REG_ADDR == rgbc_pkg::OFF_MODULE_GROUP_SELECT)
      rdata_d = grp_sel_q;
    else if (REG_ADDR == rgbc_pkg::OFF_GROUP_INTENSITY)
      rdata_d = grp_int_q;
    else if (REG_ADDR == rgbc_pkg::OFF_GROUP_FIRST_COLOR)
      rdata_d = grp_first_q;
    else if (REG_ADDR == rgbc_pkg::OFF_GROUP_SECOND_COLOR)
      rdata_d = grp_second_q;
    else if (REG_ADDR == rgbc_pkg::OFF_GROUP_THIRD_COLOR)
      rdata_d = grp_third_q;
    else if (mod_hit(REG_ADDR))
      rdata_d = mod_int_q[wr_idx[$clog2(NUM_MOD)-1:0]];
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      opt_q <= rgbc_pkg::RST_GLOBAL_OPTIONS;
    else if (wr_opt)
      opt_q <= opt_d;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      grp_sel_q <= rgbc_pkg::RST_MODULE_GROUP_SELECT;
    else if (wr_sel)
      grp_sel_q <= REG_WDATA;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      grp_int_q    <= rgbc_pkg::RST_GROUP_INTENSITY;
      grp_first_q  <= rgbc_pkg::RST_GROUP_COLOR;
      grp_second_q <= rgbc_pkg::RST_GROUP_COLOR;
      grp_third_q  <= rgbc_pkg::RST_GROUP_COLOR;
    end
    else
    begin
      if (wr_gint)
        grp_int_q <= REG_WDATA;
      if (wr_first)
        grp_first_q <= REG_WDATA;
      if (wr_second)
        grp_second_q <= REG_WDATA;
      if (wr_third)
        grp_third_q <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      mod_int_q <= {NUM_MOD{rgbc_pkg::RST_MODULE_INTENSITY}};
    else if (wr_mod)
      mod_int_q[wr_idx[$clog2(NUM_MOD)-1:0]] <= REG_WDATA;
  end

  // Read data lags the address by one clock
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      rdata_q <= rgbc_pkg::RST_READ_DATA;
    else
      rdata_q <= rdata_d;
  end

  assign REG_RDATA    = rdata_q;
  assign LOG_SCALE    = opt_q[rgbc_pkg::BIT_LOG_SCALE];
  assign POWER_SAVE   = opt_q[rgbc_pkg::BIT_POWER_SAVE];
  assign AUTO_INCR    = opt_q[rgbc_pkg::BIT_AUTO_INCR];
  assign DITHER       = opt_q[rgbc_pkg::BIT_DITHER];
  assign HIGH_CURRENT = opt_q[rgbc_pkg::BIT_HIGH_CURRENT];
  assign SHUTDOWN     = opt_q[rgbc_pkg::BIT_SHUTDOWN];
  assign GROUP_SELECT = grp_sel_q[NUM_MOD-1:0];
  assign grp_color    = {grp_third_q, grp_second_q, grp_first_q};

  // Selection is registered so every module output leaves a flop
  genvar m;
  generate
    for (m = 0; m < NUM_MOD; m++)
    begin : g_mod
      rgbc_mod_sel i_rgbc_mod_sel
      (
        .clk       (CLK),
        .nrst      (NRST),
        .group_en  (grp_sel_q[m]),
        .shutdown  (opt_q[rgbc_pkg::BIT_SHUTDOWN]),
        .grp_color (grp_color),
        .grp_int   (grp_int_q),
        .own_color (OWN_COLOR[m*3 +: 3]),
        .own_int   (mod_int_q[m]),
        .color_q   (MOD_COLOR[m*3 +: 3]),
        .int_q     (MOD_INTENSITY[m])
      );
    end
  endgenerate

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_log_scale;
    wr_opt |=> (LOG_SCALE == $past(REG_WDATA[5]));
  endproperty
  a_log_scale: assert property (p_log_scale)
    else $error("log scale bit not taken from write");

  property p_power_save;
    wr_opt ##1 !wr_opt |=> (POWER_SAVE == $past(REG_WDATA[4], 2));
  endproperty
  a_power_save: assert property (p_power_save)
    else $error("power save bit lost after write");

  property p_auto_incr;
    !wr_opt |=> $stable(AUTO_INCR);
  endproperty
  a_auto_incr: assert property (p_auto_incr)
    else $error("auto increment changed without write");

  property p_dither;
    wr_opt |=> (DITHER == $past(REG_WDATA[2]));
  endproperty
  a_dither: assert property (p_dither)
    else $error("dither bit not taken from write");

  property p_high_current;
    wr_opt |=> (HIGH_CURRENT == $past(REG_WDATA[1]));
  endproperty
  a_high_current: assert property (p_high_current)
    else $error("current range bit not taken from write");

  property p_shutdown_blank;
    SHUTDOWN |=> (MOD_COLOR == '0);
  endproperty
  a_shutdown_blank: assert property (p_shutdown_blank)
    else $error("colors not blanked under shutdown");

  property p_group_sel;
    wr_sel |=> (GROUP_SELECT == $past(REG_WDATA[NUM_MOD-1:0]));
  endproperty
  a_group_sel: assert property (p_group_sel)
    else $error("group select not updated by write");

  property p_gint_read;
    (REG_ADDR == rgbc_pkg::OFF_GROUP_INTENSITY) ##1
      (REG_ADDR == rgbc_pkg::OFF_GROUP_INTENSITY) && !REG_WR
      |=> (REG_RDATA == $past(grp_int_q));
  endproperty
  a_gint_read: assert property (p_gint_read)
    else $error("group intensity readback wrong");

  property p_group_color;
    grp_sel_q[0] && !SHUTDOWN |=>
      (MOD_COLOR[0] == $past(grp_first_q)) &&
      (MOD_COLOR[2] == $past(grp_third_q));
  endproperty
  a_group_color: assert property (p_group_color)
    else $error("grouped module color not from group registers");

  property p_mod_int;
    wr_mod && (REG_ADDR == rgbc_pkg::OFF_MODULE0_INTENSITY) && !grp_sel_q[0]
      ##1 !grp_sel_q[0] |=> (MOD_INTENSITY[0] == $past(REG_WDATA, 2));
  endproperty
  a_mod_int: assert property (p_mod_int)
    else $error("module intensity write not applied");

  property p_group_int;
    grp_sel_q[1] |=> (MOD_INTENSITY[1] == $past(grp_int_q));
  endproperty
  a_group_int: assert property (p_group_int)
    else $error("grouped module ignores group intensity");

  property p_reserved;
    opt_q[7:6] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved option bits set");

  c_shutdown: cover property (wr_opt && REG_WDATA[0] ##1 SHUTDOWN);
  c_group:    cover property (wr_sel && REG_WDATA[0] ##2 grp_sel_q[0]);
  c_mod_rd:   cover property (mod_hit(REG_ADDR) && !REG_WR ##1 1'b1);
  c_linear:   cover property (wr_opt && !REG_WDATA[5] ##1 !LOG_SCALE);

endmodule

`default_nettype wire

//--- bench/rgbc_host_model.sv
// Host-side model driving the register port of the configuration bank
`timescale 1ns/100ps
`default_nettype none

module rgbc_host_model
#(
  parameter int NUM_MOD = 8
)
(
  input  wire logic                      clk,
  input  wire logic [7:0]                rdata,
  output logic      [7:0]                addr,
  output logic                           wr,
  output logic      [7:0]                wdata,
  output logic      [NUM_MOD*3-1:0][7:0] own_color
);
  initial
  begin
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    for (int i = 0; i < NUM_MOD*3; i++)
      own_color[i] = 8'h40 + 8'(i);
  end

  // Strobe stands one cycle; data inverted once released
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wr = 1'b1;
    wdata = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
    wdata = ~d;
  endtask

  // Read data belongs to the address sampled at the previous edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    @(posedge clk);
    #1;
    d = rdata;
  endtask
endmodule

`default_nettype wire

//--- bench/tb_rgbc_cfg_bank.sv
// Self-checking testbench of the LED configuration bank
`timescale 1ns/100ps
`default_nettype none

module tb_rgbc_cfg_bank;
  localparam int NM = 8;
  localparam logic [2:0][7:0] GC = {8'h00, 8'h80, 8'hFF};
  logic                 clk;
  logic                 nrst;
  logic [7:0]           addr;
  logic [7:0]           wdata;
  logic [7:0]           rdata;
  logic                 wr;
  logic [NM*3-1:0][7:0] own_color;
  logic [NM*3-1:0][7:0] mod_color;
  logic [NM-1:0][7:0]   mod_int;
  logic [NM-1:0]        grp_sel;
  logic [5:0]           opt;
  wire  [7:0]           opts = {2'b00, opt};
  logic [7:0]           rv;
  int                   err_total = 0;
  int                   n_tests = 0;

  rgbc_cfg_bank #(.NUM_MOD(NM)) i_rgbc_cfg_bank (
    .CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .OWN_COLOR(own_color),
    .MOD_COLOR(mod_color), .MOD_INTENSITY(mod_int),
    .GROUP_SELECT(grp_sel), .LOG_SCALE(opt[5]), .POWER_SAVE(opt[4]),
    .AUTO_INCR(opt[3]), .DITHER(opt[2]), .HIGH_CURRENT(opt[1]),
    .SHUTDOWN(opt[0]));

  rgbc_host_model #(.NUM_MOD(NM)) i_rgbc_host_model (
    .clk(clk), .rdata(rdata), .addr(addr), .wr(wr), .wdata(wdata),
    .own_color(own_color));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      err_total++;
    end
  endtask

  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    i_rgbc_host_model.wr_reg(a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    i_rgbc_host_model.rd_reg(a, rv);
    check(rv, exp);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_reset;
    logic [7:0] e;
    check(opts, 8'h3C);
    check(grp_sel, 8'h00);
    for (int a = 1; a <= 14; a++)
    begin
      e = (a == 1) ? 8'h3C : (a == 3 || a >= 7) ? 8'hFF : 8'h00;
      rdc(8'(a), e);
    end
    $display("test reset done");
  endtask

  task automatic t_opts;
    for (int b = 0; b < 6; b++)
    begin
      wrr(8'h01, 8'h01 << b);
      check(opts, 8'h01 << b);
      rdc(8'h01, 8'h01 << b);
    end
    wrr(8'h01, 8'hFF);
    check(opts, 8'h3F);
    rdc(8'h01, 8'h3F);
    wrr(8'h01, 8'h3C);
    $display("test options done");
  endtask

  task automatic t_shut;
    wrr(8'h01, 8'h3D);
    @(posedge clk);
    #1;
    for (int i = 0; i < NM*3; i++)
      check(mod_color[i], 8'h00);
    wrr(8'h01, 8'h3C);
    @(posedge clk);
    #1;
    for (int i = 0; i < NM*3; i++)
      check(mod_color[i], 8'h40 + 8'(i));
    $display("test shutdown done");
  endtask

  // Boundary values FFh, 80h and 00h in the group colors
  task automatic t_grp;
    logic g;
    wrr(8'h03, 8'h80);
    for (int k = 0; k < 3; k++)
      wrr(8'h04 + 8'(k), GC[k]);
    for (int m = 0; m < NM; m++)
      wrr(8'h07 + 8'(m), 8'(m * 17));
    wrr(8'h02, 8'hA5);
    @(posedge clk);
    #1;
    check(grp_sel, 8'hA5);
    for (int m = 0; m < NM; m++)
    begin
      g = 1'(8'hA5 >> m);
      check(mod_int[m], g ? 8'h80 : 8'(m * 17));
      for (int k = 0; k < 3; k++)
        check(mod_color[m*3+k], g ? GC[k] : 8'h40 + 8'(m*3+k));
    end
    rdc(8'h03, 8'h80);
    rdc(8'h05, 8'h80);
    rdc(8'h0E, 8'h77);
    $display("test group done");
  endtask

  task automatic t_unmap;
    wrr(8'h00, 8'h55);
    wrr(8'h0F, 8'h55);
    rdc(8'h00, 8'h00);
    rdc(8'h0F, 8'h00);
    rdc(8'h02, 8'hA5);
    $display("test unmapped done");
  endtask

  initial
  begin
    nrst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_opts();
    t_shut();
    t_grp();
    t_unmap();
    finish_test();
  end

  // Watchdog against a hung run
  initial
  begin
    #100000;
    err_total++;
    finish_test();
  end
endmodule

`default_nettype wire
